// ===== hdl/i2cm_top.v
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_consts.vh"
module i2cm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire top_irq_en,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  output wire spi_sel,
  output wire irq
);
  // ****************************************
  // decoding
  // ****************************************
  function is_mapped;
    input [15:0] x;
    begin
      case (x)
        `I2CM_IDX_DATA: is_mapped = 1'b1;
        `I2CM_IDX_MODE: is_mapped = 1'b1;
        `I2CM_IDX_LIN: is_mapped = 1'b1;
        `I2CM_IDX_EXP: is_mapped = 1'b1;
        `I2CM_IDX_CTRL: is_mapped = 1'b1;
        `I2CM_IDX_STAT: is_mapped = 1'b1;
        `I2CM_IDX_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction
  function wr_hit;
    input wr;
    input [15:0] x;
    input [15:0] idx_c;
    begin
      wr_hit = wr & (x == idx_c);
    end
  endfunction
  // ****************************************
  // state
  // ****************************************
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg irq_q;
  reg spi_sel_q;
  reg scl_o_q;
  reg sda_o_q;
  reg [1:0] mode_q;
  reg [3:0] lin_q;
  reg [3:0] exp_q;
  reg [4:0] ctrl_q;
  reg [6:0] stat_q;
  reg [6:0] mask_q;
  reg [7:0] tx_data_q;
  reg tx_full_q;
  reg [7:0] rx_data_q;
  reg rx_full_q;
  reg run_q;
  reg [1:0] run_cmd_q;
  reg [1:0] scl_sy_q;
  reg [1:0] sda_sy_q;
  reg [4:0] ctrl_d;
  reg [6:0] stat_d;
  reg [1:0] go_cmd;
  reg [31:0] rd_mux;
  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_rx;
  wire eng_nack;
  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: pready rises the cycle after the access phase starts
  wire [15:0] idx = paddr[17:2];
  wire setup_acc = psel & penable & ~pready_q;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite & is_mapped(idx);
  wire rd = acc & ~pwrite & is_mapped(idx);
  wire wr_data = wr_hit(wr, idx, `I2CM_IDX_DATA);
  wire wr_mode = wr_hit(wr, idx, `I2CM_IDX_MODE);
  wire wr_lin = wr_hit(wr, idx, `I2CM_IDX_LIN);
  wire wr_exp = wr_hit(wr, idx, `I2CM_IDX_EXP);
  wire wr_ctrl = wr_hit(wr, idx, `I2CM_IDX_CTRL);
  wire wr_stat = wr_hit(wr, idx, `I2CM_IDX_STAT);
  wire wr_mask = wr_hit(wr, idx, `I2CM_IDX_MASK);
  wire rd_data = rd & (idx == `I2CM_IDX_DATA);
  always @* begin
    rd_mux = 32'h00000000;
    case (idx)
      `I2CM_IDX_DATA: rd_mux = {24'h000000, rx_data_q};
      `I2CM_IDX_MODE: rd_mux = {30'h00000000, mode_q};
      `I2CM_IDX_LIN: rd_mux = {28'h0000000, lin_q};
      `I2CM_IDX_EXP: rd_mux = {28'h0000000, exp_q};
      `I2CM_IDX_CTRL: rd_mux = {27'h0000000, ctrl_q};
      `I2CM_IDX_STAT: rd_mux = {25'h0000000, stat_q};
      `I2CM_IDX_MASK: rd_mux = {25'h0000000, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc & ~is_mapped(idx);
      // writes and unmapped reads answer with zero data
      if (setup_acc) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end
  // ****************************************
  // configuration
  // ****************************************
  // rate and mode change mid-transfer is not guarded; software must
  // disable first, a half-period count change just reshapes one phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      lin_q <= 4'h0;
      exp_q <= 4'h0;
      mask_q <= 7'h00;
    end else begin
      if (wr_mode) begin
        mode_q <= pwdata[1:0];
      end
      if (wr_lin) begin
        lin_q <= pwdata[3:0];
      end
      if (wr_exp) begin
        exp_q <= pwdata[3:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[6:0];
      end
    end
  end
  wire i2c_on = (mode_q == `I2CM_MODE_I2C);
  // half bit time in pclk cycles
  wire [19:0] half_cnt = ({16'h0000, lin_q} + 20'h00001) << exp_q;
  // ****************************************
  // request issue
  // ****************************************
  // one segment at a time; start beats send beats receive beats stop
  always @* begin
    go_cmd = `I2CM_CMD_STOP;
    if (ctrl_q[`I2CM_CTL_START]) begin
      go_cmd = `I2CM_CMD_START;
    end else if (ctrl_q[`I2CM_CTL_SEND]) begin
      go_cmd = `I2CM_CMD_WR;
    end else if (ctrl_q[`I2CM_CTL_RECV]) begin
      go_cmd = `I2CM_CMD_RD;
    end
  end
  wire go = i2c_on & ~run_q & ~eng_busy & (|ctrl_q[3:0]);
  wire go_wr = go & (go_cmd == `I2CM_CMD_WR);
  wire fin = run_q & eng_done;
  wire fin_cmd = fin & ~run_cmd_q[1];
  wire fin_wr = fin & (run_cmd_q == `I2CM_CMD_WR);
  wire fin_rd = fin & (run_cmd_q == `I2CM_CMD_RD);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      run_cmd_q <= 2'h0;
    end else begin
      if (go) begin
        run_q <= 1'b1;
        run_cmd_q <= go_cmd;
      end else if (fin || !i2c_on) begin
        run_q <= 1'b0;
      end
    end
  end
  // ****************************************
  // control register
  // ****************************************
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata[4:0];
    end
    if (fin) begin
      case (run_cmd_q)
        `I2CM_CMD_START: ctrl_d[`I2CM_CTL_START] = 1'b0;
        `I2CM_CMD_STOP: ctrl_d[`I2CM_CTL_STOP] = 1'b0;
        `I2CM_CMD_WR: ctrl_d[`I2CM_CTL_SEND] = 1'b0;
        default: ctrl_d[`I2CM_CTL_RECV] = 1'b0;
      endcase
    end
    // requests are dropped while the controller is not in i2c mode
    if (!i2c_on) begin
      ctrl_d[3:0] = 4'h0;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 5'h00;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  // ****************************************
  // one byte fifos
  // ****************************************
  wire rx_lost = fin_rd & rx_full_q & ~rd_data;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_q <= 8'h00;
      tx_full_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      // a push into a full fifo replaces the queued byte
      if (wr_data) begin
        tx_data_q <= pwdata[7:0];
        tx_full_q <= 1'b1;
      end else if (go_wr) begin
        tx_full_q <= 1'b0;
      end
      if (fin_rd && !rx_lost) begin
        rx_data_q <= eng_rx;
        rx_full_q <= 1'b1;
      end else if (rd_data) begin
        rx_full_q <= 1'b0;
      end
    end
  end
  // ****************************************
  // status flags
  // ****************************************
  // write one to clear the event flags, not the nack bit; a set in the same cycle wins over the clear
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~(pwdata[6:0] & `I2CM_EVT_MASK);
    end
    if (fin_cmd) begin
      stat_d[`I2CM_ST_CMD] = 1'b1;
    end
    if (fin_wr) begin
      stat_d[`I2CM_ST_TXD] = 1'b1;
      stat_d[`I2CM_ST_NAK] = eng_nack;
    end
    if (fin_wr && eng_nack) begin
      stat_d[`I2CM_ST_TXNAK] = 1'b1;
    end
    if (fin_rd) begin
      stat_d[`I2CM_ST_RXD] = 1'b1;
      stat_d[`I2CM_ST_NAK] = eng_nack;
    end
    if (rx_lost) begin
      stat_d[`I2CM_ST_OVF] = 1'b1;
    end
    if (go_wr && !tx_full_q) begin
      stat_d[`I2CM_ST_UND] = 1'b1;
    end
  end
  // ****************************************
  // pins, interrupt, outputs
  // ****************************************
  // each event flag only sets on its own 0 to 1 edge, so a pending flag
  // is the event; the level nack bit is kept out of the mask
  wire irq_d = top_irq_en & (|(stat_q & mask_q & `I2CM_EVT_MASK));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 7'h00;
      irq_q <= 1'b0;
      spi_sel_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
      spi_sel_q <= (mode_q == `I2CM_MODE_SPI);
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
    end
  end
  // the queued byte goes out even on underrun, so the slave receives the stale byte again
  i2cm_bit_engine u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .half_cnt(half_cnt),
    .go(go),
    .cmd(go_cmd),
    .tx_byte(tx_data_q),
    .ack_en(ctrl_q[`I2CM_CTL_ACK]),
    .scl_s(scl_sy_q[1]),
    .sda_s(sda_sy_q[1]),
    .busy(eng_busy),
    .done(eng_done),
    .rx_byte(eng_rx),
    .nack_seen(eng_nack),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign spi_sel = spi_sel_q;
  assign scl_o = scl_o_q;
  assign sda_o = sda_o_q;
endmodule
`default_nettype wire

// ===== pkg/i2cm_consts.vh
// Contract
// - Transmit and receive FIFOs each hold exactly one byte, moved by software.
// - Start or stop request bit set by software, cleared by hardware when done.
// - Command-done flag sets when a requested start or stop finishes.
// - Send shifts out the queued byte, clears its bit, sets transmit-done.
// - Receive request clocks in one byte, clears its bit, sets receive-done.
// - After each byte segment the NACK flag shows what the bus answered.
// - Event when command-done flag rises from 0 to 1.
// - Event when a transmitted byte is answered with NACK.
// - Event on each rising edge of transmit-done.
// - Event on each rising edge of receive-done.
// - Byte arriving with full receive FIFO flags overrun and is discarded.
// - Transmitting with empty transmit FIFO flags underrun.
// - Interrupt only when controller mask bit and top-level enable are set.
// - Mode field: 0 and 1 disabled, 2 SPI, 3 I2C.
// - Data port write pushes the byte into the transmit FIFO.
// - Data port read pops the oldest byte from the receive FIFO.
// - Bit period is 2*(linear+1)*2^exponent reference cycles, fields 4 bits.
`ifndef I2CM_CONSTS_VH
`define I2CM_CONSTS_VH
// register indices; byte address is four times the index
`define I2CM_IDX_DATA 16'h441E
`define I2CM_IDX_MODE 16'h442A
`define I2CM_IDX_LIN 16'h4430
`define I2CM_IDX_EXP 16'h4432
`define I2CM_IDX_CTRL 16'h4440
`define I2CM_IDX_STAT 16'h4442
`define I2CM_IDX_MASK 16'h4444
`define I2CM_MODE_SPI 2'h2
`define I2CM_MODE_I2C 2'h3
`define I2CM_RST_16 16'h0000
// control bits
`define I2CM_CTL_START 0
`define I2CM_CTL_STOP 1
`define I2CM_CTL_SEND 2
`define I2CM_CTL_RECV 3
`define I2CM_CTL_ACK 4
// status bits
`define I2CM_ST_CMD 0
`define I2CM_ST_TXD 1
`define I2CM_ST_RXD 2
`define I2CM_ST_NAK 3
`define I2CM_ST_TXNAK 4
`define I2CM_ST_OVF 5
`define I2CM_ST_UND 6
`define I2CM_EVT_MASK 7'h77
// engine commands
`define I2CM_CMD_START 2'h0
`define I2CM_CMD_STOP 2'h1
`define I2CM_CMD_WR 2'h2
`define I2CM_CMD_RD 2'h3
`define I2CM_LAST_START 5'h03
`define I2CM_LAST_STOP 5'h02
`define I2CM_LAST_BYTE 5'h11
`endif

// ===== hdl/i2cm_bit_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_consts.vh"
module i2cm_bit_engine (
  input wire pclk,
  input wire presetn,
  input wire [19:0] half_cnt,
  input wire go,
  input wire [1:0] cmd,
  input wire [7:0] tx_byte,
  input wire ack_en,
  input wire scl_s,
  input wire sda_s,
  output wire busy,
  output wire done,
  output wire [7:0] rx_byte,
  output wire nack_seen,
  output wire scl_oe,
  output wire sda_oe
);
  // ****************************************
  // line levels per phase
  // ****************************************
  // returns {scl_oe, sda_oe}; oe high pulls the wire low
  function [1:0] lines;
    input [1:0] c;
    input [4:0] p;
    input b;
    begin
      case (c)
        `I2CM_CMD_START: begin
          case (p[1:0])
            2'h0: lines = 2'h2;
            2'h1: lines = 2'h0;
            2'h2: lines = 2'h1;
            default: lines = 2'h3;
          endcase
        end
        `I2CM_CMD_STOP: begin
          case (p[1:0])
            2'h0: lines = 2'h3;
            2'h1: lines = 2'h1;
            default: lines = 2'h0;
          endcase
        end
        default: lines = {~p[0], ~b};
      endcase
    end
  endfunction
  reg busy_q;
  reg done_q;
  reg [1:0] cmd_q;
  reg [4:0] ph_q;
  reg [19:0] cnt_q;
  reg [8:0] sh_q;
  reg scl_oe_q;
  reg sda_oe_q;
  reg sda_late_q;
  reg sda_nx_q;
  wire byte_op = cmd_q[1];
  wire last_ph = (cmd_q == `I2CM_CMD_START) ? (ph_q == `I2CM_LAST_START) :
                 (cmd_q == `I2CM_CMD_STOP) ? (ph_q == `I2CM_LAST_STOP) :
                 (ph_q == `I2CM_LAST_BYTE);
  // a slave holding scl low stretches the high phase; the first two counts
  // are skipped while the synchroniser still shows the old level, so the
  // rate holds and halves under three cycles cannot be stretched
  wire stretch = ~scl_oe_q & ~scl_s & (cnt_q > 20'h00001);
  wire tick = busy_q & ~stretch & (cnt_q == half_cnt - 20'h00001);
  // sample on the end of each scl high phase of a byte
  wire [8:0] sh_n = (byte_op & ph_q[0]) ? {sh_q[7:0], sda_s} : sh_q;
  wire [4:0] ph_n = ph_q + 5'h01;
  wire [1:0] ln_go = lines(cmd, 5'h00, cmd[0] ? 1'b1 : tx_byte[7]);
  wire [1:0] ln_nx = lines(cmd_q, ph_n, sh_n[8]);
  // sda moves a cycle after a falling scl, never on the same edge,
  // or a slave could see a false start or stop
  wire fall_go = ~scl_oe_q & ln_go[1];
  wire fall_nx = ~scl_oe_q & ln_nx[1];
  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cmd_q <= 2'h0;
      ph_q <= 5'h00;
      cnt_q <= 20'h00000;
      sh_q <= 9'h000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_late_q <= 1'b0;
      sda_nx_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      sda_late_q <= 1'b0;
      if (sda_late_q) begin
        sda_oe_q <= sda_nx_q;
      end
      if (go && !busy_q) begin
        busy_q <= 1'b1;
        cmd_q <= cmd;
        ph_q <= 5'h00;
        cnt_q <= 20'h00000;
        // read releases sda for data and drives the ninth bit when acking
        sh_q <= cmd[0] ? {8'hFF, ~ack_en} : {tx_byte, 1'b1};
        scl_oe_q <= ln_go[1];
        sda_nx_q <= ln_go[0];
        sda_late_q <= fall_go;
        if (!fall_go) begin
          sda_oe_q <= ln_go[0];
        end
      end else if (tick) begin
        cnt_q <= 20'h00000;
        sh_q <= sh_n;
        if (last_ph) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          // a byte ends with scl held low so the next segment starts clean
          if (byte_op) begin
            scl_oe_q <= 1'b1;
          end
        end else begin
          ph_q <= ph_n;
          scl_oe_q <= ln_nx[1];
          sda_nx_q <= ln_nx[0];
          sda_late_q <= fall_nx;
          if (!fall_nx) begin
            sda_oe_q <= ln_nx[0];
          end
        end
      end else if (busy_q && !stretch) begin
        cnt_q <= cnt_q + 20'h00001;
      end
    end
  end
  assign busy = busy_q;
  assign done = done_q;
  assign rx_byte = sh_q[8:1];
  assign nack_seen = sh_q[0];
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ===== bench/i2cm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_consts.vh"
module i2cm_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic top_irq_en,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic spi_sel,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ******************************
  // helper logic
  // ******************************
  logic [1:0] mode_q;
  logic [15:0] idx;
  logic acc;
  logic known;
  assign idx = paddr[17:2];
  assign acc = psel && penable && pready;
  assign known = idx == `I2CM_IDX_DATA || idx == `I2CM_IDX_MODE ||
    idx == `I2CM_IDX_LIN || idx == `I2CM_IDX_EXP ||
    idx == `I2CM_IDX_CTRL || idx == `I2CM_IDX_STAT || idx == `I2CM_IDX_MASK;
  // shadow of the mode field, updated at the same edge as the register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
    end else if (acc && pwrite && idx == `I2CM_IDX_MODE) begin
      mode_q <= pwdata[1:0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // ******************************
  // properties
  // ******************************
  a_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready not one cycle after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_pulse: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_bad_index: assert property (acc && !known |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_data_byte: assert property (
    acc && !pwrite && idx == `I2CM_IDX_DATA |-> prdata[31:8] == 0)
    else $error("data port read wider than a byte");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  a_irq_gate: assert property (!top_irq_en |=> !irq)
    else $error("irq raised while top enable low");
  a_mode_spi: assert property (
    spi_sel == $past(mode_q == `I2CM_MODE_SPI))
    else $error("spi select does not follow mode field");
endmodule
`default_nettype wire

// ===== bench/i2cm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic rd_mode,
  input wire logic nack,
  input wire logic [7:0] out_byte,
  output var logic pull,
  output var logic [7:0] got,
  output var int starts,
  output var int stops,
  output var int per_ns
);
  int bitn = 0;
  logic [7:0] sh = 8'h00;
  time last = 0;
  initial begin
    pull = 1'h0;
    got = 8'h00;
    starts = 0;
    stops = 0;
    per_ns = 0;
  end
  always @(negedge sda) if (scl === 1'b1 && $time > 0) begin
    starts++;
    bitn = 0;
  end
  always @(posedge sda) if (scl === 1'b1 && $time > 0) stops++;
  always @(posedge scl) begin
    per_ns = int'($time - last);
    last = $time;
    if (bitn < 8) sh = {sh[6:0], sda};
    bitn++;
    if (bitn == 9) begin
      got = sh;
      bitn = 0;
    end
  end
  // data only moves while scl is low, or the master would see a stop
  always @(negedge scl or rd_mode or out_byte) if (!scl) begin
    if (bitn == 8) pull = !rd_mode && !nack;
    else pull = rd_mode && !out_byte[7 - bitn];
  end
endmodule
`default_nettype wire

// ===== bench/i2c_master_byte_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_consts.vh"
`define I2CM_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module i2c_master_byte_controller_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic top_irq_en = 1'h0;
  logic rd_mode = 1'h0;
  logic nack = 1'h0;
  logic pull;
  logic [7:0] sbyte = 8'h00;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] got;
  logic [64:0] e;
  logic [64:0] q[$];
  logic [15:0] regs[6] = '{`I2CM_IDX_MODE, `I2CM_IDX_LIN, `I2CM_IDX_EXP,
    `I2CM_IDX_CTRL, `I2CM_IDX_STAT, `I2CM_IDX_MASK};
  wire [31:0] prdata;
  wire pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, spi_sel, irq;
  // lines are pulled up; the slave never stretches the clock
  // an unknown enable before reset reads as a released line
  wire scl_w = scl_oe !== 1'h1;
  wire sda_w = !(sda_oe === 1'h1 || pull === 1'h1);
  int miscompares = 0;
  int comparisons = 0;
  int starts, stops, per_ns;
  always #50 pclk = ~pclk;
  i2cm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .top_irq_en, .scl_i(scl_w), .scl_o, .scl_oe,
    .sda_i(sda_w), .sda_o, .sda_oe, .spi_sel, .irq);
  i2cm_slave_model slv (.scl(scl_w), .sda(sda_w), .rd_mode, .nack,
    .out_byte(sbyte), .pull, .got, .starts, .stops, .per_ns);
  // ******************************
  // bus tasks and monitor
  // ******************************
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] i,
      input logic [31:0] d, input logic [31:0] m, input logic [31:0] x,
      input logic er = 1'h0);
    int n;
    n = 0;
    q.push_back({er, x, m});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
    @(posedge pclk);
  endtask
  always @(posedge pclk) if (psel && penable && pready === 1'h1) begin
    e = q.pop_front();
    `I2CM_CHK({pslverr, prdata & e[31:0]}, e[64:32])
  end
  task automatic poll(input int b);
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'h0, `I2CM_IDX_CTRL, 32'h0, 32'h0, 32'h0);
      if (rd[b] === 1'h0) break;
    end
    if (k == 100) begin
      miscompares++;
      final_report();
    end
  endtask
  // one segment: request, wait for the bit to clear, check and clear status
  task automatic seg(input logic [31:0] c, input int b,
      input logic [31:0] m, input logic [31:0] x);
    apb(1'h1, `I2CM_IDX_CTRL, c, 32'h0, 32'h0);
    poll(b);
    apb(1'h0, `I2CM_IDX_STAT, 32'h0, m, x);
    apb(1'h1, `I2CM_IDX_STAT, 32'h7F, 32'h0, 32'h0);
  endtask
  // ******************************
  // scenarios
  // ******************************
  initial begin
    void'($urandom(41));
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (regs[j]) apb(1'h0, regs[j], 32'h0, 32'hFFFF, 32'h0);
    apb(1'h0, 16'h4400, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1);
    apb(1'h1, `I2CM_IDX_LIN, 32'h1, 32'h0, 32'h0);
    apb(1'h1, `I2CM_IDX_EXP, 32'h1, 32'h0, 32'h0);
    apb(1'h1, `I2CM_IDX_MASK, 32'h77, 32'h0, 32'h0);
    apb(1'h1, `I2CM_IDX_MODE, 32'h2, 32'h0, 32'h0);
    @(posedge pclk);
    `I2CM_CHK(spi_sel, 1'h1)
    apb(1'h1, `I2CM_IDX_CTRL, 32'h1, 32'h0, 32'h0);
    apb(1'h0, `I2CM_IDX_CTRL, 32'h0, 32'hF, 32'h0);
    apb(1'h1, `I2CM_IDX_MODE, 32'h0, 32'h0, 32'h0);
    apb(1'h1, `I2CM_IDX_MODE, 32'h3, 32'h0, 32'h0);
    `I2CM_CHK(spi_sel, 1'h0)
    top_irq_en <= 1'h1;
    apb(1'h1, `I2CM_IDX_CTRL, 32'h1, 32'h0, 32'h0);
    poll(`I2CM_CTL_START);
    @(posedge pclk);
    `I2CM_CHK(irq, 1'h1)
    top_irq_en <= 1'h0;
    repeat (2) @(posedge pclk);
    `I2CM_CHK(irq, 1'h0)
    top_irq_en <= 1'h1;
    apb(1'h1, `I2CM_IDX_MASK, 32'h0, 32'h0, 32'h0);
    @(posedge pclk);
    `I2CM_CHK(irq, 1'h0)
    apb(1'h1, `I2CM_IDX_MASK, 32'h77, 32'h0, 32'h0);
    apb(1'h0, `I2CM_IDX_STAT, 32'h0, 32'h7F, 32'h01);
    apb(1'h1, `I2CM_IDX_STAT, 32'h7F, 32'h0, 32'h0);
    @(posedge pclk);
    `I2CM_CHK(irq, 1'h0)
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    apb(1'h1, `I2CM_IDX_DATA, {24'h0, b0}, 32'h0, 32'h0);
    seg(32'h4, `I2CM_CTL_SEND, 32'h5A, 32'h02);
    `I2CM_CHK(got, b0)
    `I2CM_CHK(per_ns, 800)
    nack <= 1'h1;
    apb(1'h1, `I2CM_IDX_DATA, {24'h0, b1}, 32'h0, 32'h0);
    seg(32'h4, `I2CM_CTL_SEND, 32'h5A, 32'h1A);
    nack <= 1'h0;
    seg(32'h4, `I2CM_CTL_SEND, 32'h40, 32'h40);
    sbyte <= b1;
    rd_mode <= 1'h1;
    seg(32'h18, `I2CM_CTL_RECV, 32'h2C, 32'h04);
    apb(1'h0, `I2CM_IDX_DATA, 32'h0, 32'hFF, {24'h0, b1});
    sbyte <= b0;
    seg(32'h18, `I2CM_CTL_RECV, 32'h2C, 32'h04);
    sbyte <= ~b0;
    seg(32'h18, `I2CM_CTL_RECV, 32'h20, 32'h20);
    rd_mode <= 1'h0;
    apb(1'h0, `I2CM_IDX_DATA, 32'h0, 32'hFF, {24'h0, b0});
    seg(32'h2, `I2CM_CTL_STOP, 32'h01, 32'h01);
    `I2CM_CHK(starts, 1)
    `I2CM_CHK(stops, 1)
    final_report();
  end
endmodule
bind i2cm_top i2cm_top_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .top_irq_en, .scl_i, .scl_o,
  .scl_oe, .sda_i, .sda_o, .sda_oe, .spi_sel, .irq);
`default_nettype wire
